/* File: src/spcr_top.sv */
`timescale 1ns/10ps
module spcr_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic serial_out_pin,
  output logic serial_out_pin_oe,
  output logic [spcr_pkg::CFG_SOFT_RST_BIT:0] prescaler_a_count,
  output logic soft_reset_active
);
  import spcr_pkg::*;

  logic [2:0] raw_in;
  logic [2:0] lvl;
  logic [2:0] rise;
  logic [2:0] fall;

  // ---------------------------------------------------------------
  // Input synchronisers: link clock, select and data pin
  // ---------------------------------------------------------------
  // Select is synchronised active high so that reset reads as deselected
  assign raw_in = {sdio_in, ~cs_n, sclk};
  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      spcr_sync u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .async_in(raw_in[i]),
        .level(lvl[i]),
        .rise(rise[i]),
        .fall(fall[i])
      );
    end
  endgenerate

  wire sclk_rise = rise[0];
  wire sclk_fall = fall[0];
  wire sel_n = ~lvl[1];
  wire din = lvl[2];

  spcr_state_t state_ff, nxt_state;
  logic [7:0] cfg_ff;
  logic [5:0] a_buf_ff;
  logic [5:0] a_act_ff;
  logic [15:0] sh_ff, nxt_sh;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [12:0] addr_ff, nxt_addr;
  logic [1:0] left_ff, nxt_left;
  logic rd_ff, nxt_rd;
  logic stream_ff, nxt_stream;
  logic [7:0] tx_ff, nxt_tx;
  logic out_ff;
  logic sdo_oe_ff;
  logic sdio_oe_ff;

  // ---------------------------------------------------------------
  // Decode of bit order, shift and register read data
  // ---------------------------------------------------------------
  wire lsb_first = cfg_ff[CFG_LSB_FIRST_BIT];
  wire sdo_off = cfg_ff[CFG_SDO_OFF_BIT];
  // LSB first enters at the top so the word lands in the same place
  wire [15:0] sh_in = lsb_first ? {din, sh_ff[15:1]}
                                : {sh_ff[14:0], din};
  wire [7:0] rx_byte = lsb_first ? sh_in[15:8] : sh_in[7:0];
  wire instr_done = (state_ff == SPCR_INSTR) && sclk_rise
                    && (cnt_ff == INSTR_LAST_BIT);
  wire byte_done = (state_ff == SPCR_DATA) && sclk_rise
                   && (cnt_ff == BYTE_LAST_BIT);
  wire [12:0] step_addr = lsb_first ? addr_ff + 13'h0001
                                    : addr_ff - 13'h0001;
  wire [12:0] first_addr = sh_in[12:0];
  wire [12:0] rd_addr = instr_done ? first_addr : step_addr;
  wire wr_en = byte_done && !rd_ff;
  wire wr_cfg = wr_en && (addr_ff == ADDR_CFG);
  wire wr_a = wr_en && (addr_ff == ADDR_PRESCALE_A);
  wire wr_upd = wr_en && (addr_ff == ADDR_UPDATE) && rx_byte[UPDATE_BIT];
  wire soft_rst = cfg_ff[CFG_SOFT_RST_BIT];
  wire [7:0] rd_data = (rd_addr == ADDR_CFG) ? cfg_ff :
                       (rd_addr == ADDR_PRESCALE_A) ? {2'b00, a_buf_ff} :
                       8'h00;
  // Current outgoing bit, indexed by bit order
  wire [2:0] bit_idx = lsb_first ? cnt_ff[2:0] : 3'h7 - cnt_ff[2:0];
  wire out_bit = tx_ff[bit_idx];

  // ---------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------
  // Deselect aborts any frame; a partial byte is discarded
  always_comb begin
    nxt_state = state_ff;
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_addr = addr_ff;
    nxt_left = left_ff;
    nxt_rd = rd_ff;
    nxt_stream = stream_ff;
    nxt_tx = tx_ff;
    if (sel_n) begin
      nxt_state = SPCR_IDLE;
      nxt_cnt = 4'h0;
    end else begin
      unique case (state_ff)
        SPCR_IDLE: begin
          nxt_state = SPCR_INSTR;
          nxt_cnt = 4'h0;
        end
        SPCR_INSTR: begin
          if (sclk_rise) begin
            nxt_sh = sh_in;
            nxt_cnt = cnt_ff + 4'h1;
          end
          if (instr_done) begin
            nxt_state = SPCR_DATA;
            nxt_cnt = 4'h0;
            nxt_rd = sh_in[INSTR_RW_BIT];
            nxt_left = sh_in[INSTR_LEN_MSB:INSTR_LEN_LSB];
            nxt_stream = (sh_in[INSTR_LEN_MSB:INSTR_LEN_LSB] == LEN_STREAM);
            nxt_addr = first_addr;
            nxt_tx = rd_data;
          end
        end
        SPCR_DATA: begin
          if (sclk_rise) begin
            nxt_sh = sh_in;
            nxt_cnt = cnt_ff + 4'h1;
          end
          if (byte_done) begin
            nxt_cnt = 4'h0;
            nxt_addr = step_addr;
            nxt_tx = rd_data;
            nxt_left = left_ff - 2'h1;
            if (!stream_ff && left_ff == 2'h0) begin
              nxt_state = SPCR_HOLD;
            end
          end
        end
        SPCR_HOLD: begin
          nxt_state = SPCR_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= SPCR_IDLE;
      sh_ff <= 16'h0000;
      cnt_ff <= 4'h0;
      addr_ff <= 13'h0000;
      left_ff <= 2'h0;
      rd_ff <= 1'b0;
      stream_ff <= 1'b0;
      tx_ff <= 8'h00;
    end else if (ce) begin
      state_ff <= nxt_state;
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      addr_ff <= nxt_addr;
      left_ff <= nxt_left;
      rd_ff <= nxt_rd;
      stream_ff <= nxt_stream;
      tx_ff <= nxt_tx;
    end
  end

  // ---------------------------------------------------------------
  // Register bank
  // ---------------------------------------------------------------
  // Configuration is written directly, never through the update path
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_ff <= CFG_RESET;
    end else if (ce && wr_cfg) begin
      cfg_ff <= {rx_byte[7:5], 1'b1, 4'h0};
    end
  end

  // Soft reset pins the other registers at default while bit 5 is set
  always_ff @(posedge core_clk) begin
    if (rst || (ce && soft_rst)) begin
      a_buf_ff <= PRESCALE_A_RESET;
      a_act_ff <= PRESCALE_A_RESET;
    end else if (ce) begin
      if (wr_a) begin
        a_buf_ff <= rx_byte[5:0];
      end
      if (wr_upd) begin
        a_act_ff <= a_buf_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output data bit, changed on the falling link clock edge; serial output enable follows mode, data pin enable mode and state
  // ---------------------------------------------------------------
  // Host samples on the rising edge, so half a period of setup remains
  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_ff <= 1'b0;
      sdo_oe_ff <= 1'b1;
      sdio_oe_ff <= 1'b0;
    end else if (ce) begin
      if (sclk_fall && state_ff == SPCR_DATA && rd_ff) begin
        out_ff <= out_bit;
      end
      sdo_oe_ff <= !sdo_off;
      sdio_oe_ff <= sdo_off && rd_ff && (state_ff == SPCR_DATA)
                    && !sel_n;
    end
  end

  assign sdio_out = out_ff;
  assign sdio_oe = sdio_oe_ff;
  assign serial_out_pin = out_ff;
  assign serial_out_pin_oe = sdo_oe_ff;
  assign prescaler_a_count = a_act_ff;
  assign soft_reset_active = cfg_ff[CFG_SOFT_RST_BIT];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_cfg_takes_effect: assert property (
    ce && wr_cfg |=> cfg_ff[7:5] == $past(rx_byte[7:5]))
    else $error("config write did not take effect at once");
  a_long_instr_set: assert property (
    cfg_ff[CFG_LONG_BIT] == 1'b1)
    else $error("long instruction bit not set");
  a_soft_rst_hold: assert property (
    ce && soft_rst ##1 ce |=> a_buf_ff == PRESCALE_A_RESET
      && a_act_ff == PRESCALE_A_RESET)
    else $error("soft reset did not restore defaults");
  a_soft_rst_sticky: assert property (
    soft_rst && !(ce && wr_cfg) |=> soft_rst)
    else $error("soft reset bit cleared itself");
  a_addr_increments: assert property (
    ce && byte_done && lsb_first |=> addr_ff == $past(addr_ff) + 13'h0001)
    else $error("address did not increment");
  a_addr_decrements: assert property (
    ce && byte_done && !lsb_first |=> addr_ff == $past(addr_ff) - 13'h0001)
    else $error("address did not decrement");
  a_bit_order_out: assert property (
    ce && sclk_fall && state_ff == SPCR_DATA && rd_ff && cnt_ff == 4'h0
    |=> out_ff == ($past(lsb_first) ? $past(tx_ff[0]) : $past(tx_ff[7])))
    else $error("first read bit has wrong order");
  a_sdo_tristate: assert property (
    ce && sdo_off |=> !serial_out_pin_oe)
    else $error("serial output driven in bidirectional mode");
  a_sdo_driving: assert property (
    ce && !sdo_off |=> serial_out_pin_oe && !sdio_oe)
    else $error("serial output not driving in unidirectional mode");

  c_write_cfg: cover property (ce && wr_cfg);
  c_read_burst: cover property (ce && byte_done && rd_ff && lsb_first);
  c_update_a: cover property (ce && wr_upd);
  c_bidir_read: cover property (sdio_oe);
endmodule

/* File: src/spcr_pkg.sv */
package spcr_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [12:0] ADDR_CFG = 13'h0000;
  localparam logic [12:0] ADDR_PRESCALE_A = 13'h0004;
  localparam logic [12:0] ADDR_UPDATE = 13'h005A;

  // ---------------------------------------------------------------
  // Configuration fields and reset values
  // ---------------------------------------------------------------
  localparam int CFG_LONG_BIT = 4;
  localparam int CFG_SOFT_RST_BIT = 5;
  localparam int CFG_LSB_FIRST_BIT = 6;
  localparam int CFG_SDO_OFF_BIT = 7;
  localparam int UPDATE_BIT = 0;
  localparam logic [7:0] CFG_RESET = 8'h10;
  localparam logic [5:0] PRESCALE_A_RESET = 6'h00;

  // ---------------------------------------------------------------
  // Instruction word layout and counts
  // ---------------------------------------------------------------
  localparam int INSTR_RW_BIT = 15;
  localparam int INSTR_LEN_MSB = 14;
  localparam int INSTR_LEN_LSB = 13;
  localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  typedef enum logic [1:0] {
    SPCR_IDLE = 2'b00,
    SPCR_INSTR = 2'b01,
    SPCR_DATA = 2'b10,
    SPCR_HOLD = 2'b11
  } spcr_state_t;
endpackage

/* File: src/spcr_sync.sv */
`timescale 1ns/10ps
module spcr_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_ff;
  logic stable_ff;
  logic last_ff;

  // ---------------------------------------------------------------
  // Two-flop synchroniser plus one history flop for edges
  // ---------------------------------------------------------------
  // Only stable_ff looks at meta_ff; edges come from later stages
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      stable_ff <= 1'b0;
      last_ff <= 1'b0;
    end else if (ce) begin
      meta_ff <= async_in;
      stable_ff <= meta_ff;
      last_ff <= stable_ff;
    end
  end

  // Edge pulses last one core cycle
  assign level = stable_ff;
  assign rise = stable_ff & ~last_ff;
  assign fall = ~stable_ff & last_ff;
endmodule

/* File: test/spcr_host.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Host controller model for the serial control port
// ---------------------------------------------------------------
module spcr_host (
  input wire logic core_clk,
  output logic sclk,
  output logic cs_n,
  output wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic serial_out_pin
);
  logic h_bit;
  logic h_oe;
  logic lsb_m;
  logic bidir_m;
  logic oe_last;

  // Released line shows the inverse of the last bit, never a stale copy
  assign sdio_in = sdio_oe ? sdio_out : (h_oe ? h_bit : ~h_bit);

  // Link clock stands low outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    h_bit = 1'b0;
    h_oe = 1'b1;
    lsb_m = 1'b0;
    bidir_m = 1'b0;
    oe_last = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One bit: data set after a fall, read bit taken at the rise
  task automatic link_bit(input logic b, output logic r);
    h_bit = b;
    wait_n(4);
    r = bidir_m ? sdio_in : serial_out_pin;
    oe_last = sdio_oe;
    sclk = 1'b1;
    wait_n(4);
    sclk = 1'b0;
  endtask

  // Whole frame: instruction, then one to four data bytes
  task automatic xfer(input logic rd, input logic [12:0] addr, input int nb,
                      input logic [15:0] wd, output logic [15:0] rv);
    logic [15:0] word;
    logic [7:0] by;
    logic [7:0] rb;
    logic r;
    word = {rd, 2'(nb - 1), addr};
    rv = 16'h0000;
    cs_n = 1'b0;
    wait_n(4);
    for (int i = 0; i < 16; i++) begin
      link_bit(lsb_m ? word[i] : word[15 - i], r);
    end
    // In three-wire reads the host lets go of the data pin
    h_oe = ~(rd & bidir_m);
    for (int b = 0; b < nb; b++) begin
      by = (b == 0 && nb == 2) ? wd[15:8] : wd[7:0];
      for (int i = 0; i < 8; i++) begin
        link_bit(lsb_m ? by[i] : by[7 - i], r);
        rb[lsb_m ? i : 7 - i] = r;
      end
      rv = {rv[7:0], rb};
    end
    wait_n(4);
    cs_n = 1'b1;
    h_oe = 1'b1;
    wait_n(8);
  endtask
endmodule

/* File: test/spcr_top_test.sv */
`timescale 1ns/10ps
module spcr_top_test;
  import spcr_pkg::*;
  logic core_clk, rst, ce, sclk, cs_n;
  wire logic sdio_in;
  logic sdio_out, sdio_oe, serial_out_pin, serial_out_pin_oe;
  logic soft_reset_active;
  logic [CFG_SOFT_RST_BIT:0] prescaler_a_count;
  logic [15:0] rv;
  int mismatches = 0;
  int comparisons = 0;

  spcr_top i_spcr_top (.core_clk(core_clk), .rst(rst), .ce(ce),
    .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .serial_out_pin(serial_out_pin),
    .serial_out_pin_oe(serial_out_pin_oe),
    .prescaler_a_count(prescaler_a_count),
    .soft_reset_active(soft_reset_active));

  spcr_host i_spcr_host (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_out_pin(serial_out_pin));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [12:0] a, input int nb, input logic [15:0] d);
    i_spcr_host.xfer(1'b0, a, nb, d, rv);
  endtask

  task automatic rd(input logic [12:0] a, input int nb);
    i_spcr_host.xfer(1'b1, a, nb, 16'h0000, rv);
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Watchdog, about five times the expected run
  initial begin
    #2000000;
    mismatches++;
    wrap_up;
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b0;
    i_spcr_host.wait_n(4);
    check("sdo_oe_rst", {15'h0000, serial_out_pin_oe}, 16'h0001);
    rd(ADDR_CFG, 1);
    check("cfg_rst", rv, 16'h0010);
    // The host keeps the long form bit set on every write
    wr(ADDR_CFG, 1, 16'h0010);
    rd(ADDR_CFG, 1);
    check("cfg_long", rv, 16'h0010);
    wr(ADDR_PRESCALE_A, 1, 16'h002A);
    wr(ADDR_UPDATE, 1, 16'h0001);
    check("a_count", {10'h000, prescaler_a_count}, 16'h002A);
    // Soft reset set, held, then cleared by the host
    wr(ADDR_CFG, 1, 16'h0030);
    check("soft_on", {15'h0000, soft_reset_active}, 16'h0001);
    check("a_soft", {10'h000, prescaler_a_count}, 16'h0000);
    rd(ADDR_CFG, 1);
    check("cfg_kept", rv, 16'h0030);
    rd(ADDR_PRESCALE_A, 1);
    check("buf_soft", rv, 16'h0000);
    // Four-wire read never turns the data pin around
    check("uni_oe", {15'h0000, i_spcr_host.oe_last}, 16'h0000);
    check("soft_held", {15'h0000, soft_reset_active}, 16'h0001);
    wr(ADDR_CFG, 1, 16'h0010);
    check("soft_off", {15'h0000, soft_reset_active}, 16'h0000);
    // MSB first: second byte lands one address lower
    wr(13'h0005, 2, 16'hAA15);
    rd(13'h0005, 2);
    check("dec", rv, 16'h0015);
    // LSB first: second byte lands one address higher
    wr(ADDR_CFG, 1, 16'h0050);
    i_spcr_host.lsb_m = 1'b1;
    wr(13'h0003, 2, 16'h0027);
    rd(ADDR_PRESCALE_A, 2);
    check("inc", rv, 16'h2700);
    // Streaming read from 0x01 walks up to the count buffer
    rd(13'h0001, 4);
    check("stream", rv, 16'h0027);
    rd(ADDR_CFG, 1);
    check("cfg_lsb", rv, 16'h0050);
    // Three-wire: serial output floats, reads on the data pin
    wr(ADDR_CFG, 1, 16'h00D0);
    i_spcr_host.bidir_m = 1'b1;
    check("sdo_off", {15'h0000, serial_out_pin_oe}, 16'h0000);
    rd(ADDR_PRESCALE_A, 1);
    check("bidir", rv, 16'h0027);
    check("bidir_oe", {15'h0000, i_spcr_host.oe_last}, 16'h0001);
    wrap_up;
  end
endmodule
